// file: rtl/sci_drive.sv
// The register addresses and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
// Notes on behaviour
// - Servo enable powers the motor
// - Forward limit applies selected over-travel action
// - Reverse limit applies selected over-travel action
// - Host avoids limit action value one
// - Default mode clears counter on rising edge
// - Modes 1,2 hold clear while input active
// - Modes 3,4 clear once per edge
// - Clear function only on line seven
// - Fault clear releases non-sticky alarms only
// - Pulse block input discards command pulses
// - Pulse block honoured only when disable is zero
// - Pulse block function only on line ten
// - Mode select picks one of two loops
// - Host quiet ten ms around mode change
// - Gear inputs pick numerator, common denominator
// - Damping inputs form two-bit index
module sci_drive
  import sci_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  sci_link_if.drive link,
  input wire logic [1:0] travel_limit_action_cfg_i,
  input wire logic [2:0] clear_input_mode_cfg_i,
  input wire logic [1:0] pulse_block_disable_cfg_i,
  input wire logic [3:0] clear_line_cfg_i,
  input wire logic [3:0] block_line_cfg_i,
  input wire logic [7:0] alarm_raise_i,
  output logic motor_energize_o,
  output logic fwd_inhibit_o,
  output logic rev_inhibit_o,
  output logic limit_stop_o,
  output logic dev_clear_o,
  output logic cmd_step_o,
  output logic cmd_dir_o,
  output logic cfg_error_o,
  output logic [7:0] alarm_o,
  output logic loop_select_o,
  output logic [1:0] gear_index_o,
  output logic [1:0] damping_index_o
);
  localparam int NIN = 13;

  // Synchronised line map, bit by bit:
  //   0  servo enable
  //   1  forward travel limit
  //   2  reverse travel limit
  //   3  deviation clear
  //   4  fault clear
  //   5  pulse block
  //   6  mode select
  //   7  gear select, low bit
  //   8  gear select, high bit
  //   9  damping select, low bit
  //   10 damping select, high bit
  //   11 command pulse
  //   12 command direction
  // Every output driven from a link line lags its pin by three clocks: two sync stages, one register.
  // A level shorter than one clock may be missed;
  // the host holds every line at least one clock, the command pulse exactly one, so this does not limit use.

  // Fixed lines must exist in the input map
  if (SCI_NUM_LINES <= 10) begin : g_map_chk
    $error("input map too small for the fixed lines");
  end

  // Registered state: outputs first, then the edge history

  typedef struct packed {
    logic motor;
    logic fwd_inh;
    logic rev_inh;
    logic lim_stop;
    logic dclr;
    logic step;
    logic dir;
    logic cfg_err;
    logic [7:0] alarm;
    logic loop_sel;
    logic [1:0] gear;
    logic [1:0] damp;
    logic clr_prev;
    logic fclr_prev;
    logic pulse_prev;
  } sci_drive_s;

  sci_drive_s st_r;
  sci_drive_s st_nxt;
  logic [NIN-1:0] raw;
  logic [NIN-1:0] syn;
  logic clr_lvl;
  logic blk_lvl;

  // Gather the lines in map order, highest bit first
  assign raw = {link.cmd_dir,
                link.cmd_pulse,
                link.damping_select_1,
                link.damping_select_0,
                link.gear_select_1,
                link.gear_select_0,
                link.mode_select_in,
                link.pulse_block_in,
                link.fault_clear_in,
                link.deviation_clear_in,
                link.rev_travel_limit_in,
                link.fwd_travel_limit_in,
                link.servo_enable_in};

  // Pins are asynchronous to the drive clock
  // One shared synchroniser keeps all lines aligned to the same edge,
  // so combined inputs such as the gear pair change together
  sci_sync #(
    .W(NIN)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i(raw),
    .q_o(syn)
  );

  // A misplaced function is dead: it acts only from its fixed line
  // Gating here keeps a wrong placement from clearing or blocking anything
  assign clr_lvl = syn[3] && (clear_line_cfg_i == SCI_LINE_CLEAR);
  assign blk_lvl = syn[5] && (block_line_cfg_i == SCI_LINE_BLOCK);

  // Next-state logic for every function
  always_comb begin
    st_nxt = st_r;

    // Previous levels, kept for edge detection
    st_nxt.clr_prev = clr_lvl;
    st_nxt.fclr_prev = syn[4];
    st_nxt.pulse_prev = syn[11];

    // Servo power follows its line
    st_nxt.motor = syn[0];

    // Action value one leaves the limits without effect
    st_nxt.fwd_inh = syn[1] && (travel_limit_action_cfg_i != SCI_LIMIT_ACT_NONE);
    st_nxt.rev_inh = syn[2] && (travel_limit_action_cfg_i != SCI_LIMIT_ACT_NONE);
    // Stop action adds a hard stop on top of the inhibit
    st_nxt.lim_stop = (st_nxt.fwd_inh || st_nxt.rev_inh) &&
                      (travel_limit_action_cfg_i == SCI_LIMIT_ACT_STOP);

    // Placement is checked every cycle, so fixing it clears the error
    st_nxt.cfg_err = (clear_line_cfg_i != SCI_LINE_CLEAR) ||
                     (block_line_cfg_i != SCI_LINE_BLOCK);
    // Deviation clear: level modes hold, edge modes pulse once
    case (clear_input_mode_cfg_i)
      SCI_CLR_LVL_A, SCI_CLR_LVL_B: st_nxt.dclr = clr_lvl;
      SCI_CLR_EDGE_A, SCI_CLR_EDGE_B: st_nxt.dclr = clr_lvl && !st_r.clr_prev;
      default: st_nxt.dclr = clr_lvl && !st_r.clr_prev;
    endcase

    // Command pulses pass unless blocked; blocked only when disable is zero
    st_nxt.step = syn[11] && !st_r.pulse_prev &&
                  !(blk_lvl && (pulse_block_disable_cfg_i == 2'h0));
    // Direction passes as a level; the host sets it in the same cycle as the pulse
    st_nxt.dir = syn[12];

    // Alarms latch; a fault clear edge releases all but sticky classes
    st_nxt.alarm = st_r.alarm;
    if (syn[4] && !st_r.fclr_prev) begin
      st_nxt.alarm = st_r.alarm & SCI_ALARM_STICKY;
    end
    st_nxt.alarm = st_nxt.alarm | alarm_raise_i; // raise wins over clear

    // Mode, gear and damping selections are plain levels
    st_nxt.loop_sel = syn[6];
    st_nxt.gear = {syn[8], syn[7]};
    st_nxt.damp = {syn[10], syn[9]};
  end

  // One register for the whole state; reset clears every output
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register

  // Motion and limit outputs
  assign motor_energize_o = st_r.motor;
  assign fwd_inhibit_o = st_r.fwd_inh;
  assign rev_inhibit_o = st_r.rev_inh;
  assign limit_stop_o = st_r.lim_stop;
  assign dev_clear_o = st_r.dclr;
  assign cmd_step_o = st_r.step;
  assign cmd_dir_o = st_r.dir;

  // Status and selection outputs
  assign cfg_error_o = st_r.cfg_err;
  assign alarm_o = st_r.alarm;
  assign loop_select_o = st_r.loop_sel;
  assign gear_index_o = st_r.gear;
  assign damping_index_o = st_r.damp;

  // Status back to the host, also registered
  assign link.alarm_active = |st_r.alarm;
  assign link.servo_on = st_r.motor;
endmodule

// file: rtl/sci_pkg.sv
package sci_pkg;
  // Size of the logical input map
  localparam int SCI_NUM_LINES = 12;
  localparam logic [3:0] SCI_LINE_CLEAR = 4'h7;
  localparam logic [3:0] SCI_LINE_BLOCK = 4'hA;
  // Travel limit action value that disables the limit inputs
  localparam logic [1:0] SCI_LIMIT_ACT_NONE = 2'h1;
  // Travel limit action value that adds a hard stop
  localparam logic [1:0] SCI_LIMIT_ACT_STOP = 2'h2;
  // Clear input modes
  localparam logic [2:0] SCI_CLR_EDGE_DEF = 3'h0;
  localparam logic [2:0] SCI_CLR_LVL_A = 3'h1;
  localparam logic [2:0] SCI_CLR_LVL_B = 3'h2;
  localparam logic [2:0] SCI_CLR_EDGE_A = 3'h3;
  localparam logic [2:0] SCI_CLR_EDGE_B = 3'h4;
  // Minimum pulse widths, microseconds
  localparam int SCI_CLK_MHZ = 200;
  localparam int SCI_CLR_MIN_A_US = 500;
  localparam int SCI_CLR_MIN_B_US = 1000;
  localparam int SCI_CLR_MIN_C_US = 100;
  localparam int SCI_CLR_MIN_A_CYC = SCI_CLR_MIN_A_US * SCI_CLK_MHZ;
  localparam int SCI_CLR_MIN_B_CYC = SCI_CLR_MIN_B_US * SCI_CLK_MHZ;
  localparam int SCI_CLR_MIN_C_CYC = SCI_CLR_MIN_C_US * SCI_CLK_MHZ;
  // Quiet time around a mode change, microseconds
  localparam int SCI_MODE_QUIET_US = 10000;
  localparam int SCI_MODE_QUIET_CYC = SCI_MODE_QUIET_US * SCI_CLK_MHZ;
  // Alarm classes: bit set means fault clear cannot release it
  localparam logic [7:0] SCI_ALARM_STICKY = 8'hC0;
  // Wishbone register offsets of the host controller
  localparam logic [7:0] SCI_REG_CTRL = 8'h00;
  localparam logic [7:0] SCI_REG_CFG = 8'h04;
  localparam logic [7:0] SCI_REG_STAT = 8'h08;
  localparam logic [7:0] SCI_REG_IRQ = 8'h0C;
  localparam logic [7:0] SCI_REG_MASK = 8'h10;
  localparam logic [7:0] SCI_REG_PULSE = 8'h14;
  // Interrupt status bits
  localparam int SCI_IRQ_CFG_ERR = 0;
  localparam int SCI_IRQ_MODE_DONE = 1;
  localparam int SCI_IRQ_ALARM = 2;
  localparam int SCI_IRQ_W = 3;
endpackage

// file: rtl/sci_link_if.sv
`timescale 1ns/1ps
// Discrete control lines from the host to the drive, plus drive status back
interface sci_link_if;
  logic servo_enable_in;
  logic fwd_travel_limit_in;
  logic rev_travel_limit_in;
  logic deviation_clear_in;
  logic fault_clear_in;
  logic pulse_block_in;
  logic mode_select_in;
  logic gear_select_0;
  logic gear_select_1;
  logic damping_select_0;
  logic damping_select_1;
  logic cmd_pulse;
  logic cmd_dir;
  logic alarm_active;
  logic servo_on;
  modport host (
    output servo_enable_in, fwd_travel_limit_in, rev_travel_limit_in,
    output deviation_clear_in, fault_clear_in, pulse_block_in, mode_select_in,
    output gear_select_0, gear_select_1, damping_select_0, damping_select_1,
    output cmd_pulse, cmd_dir,
    input alarm_active, servo_on
  );
  modport drive (
    input servo_enable_in, fwd_travel_limit_in, rev_travel_limit_in,
    input deviation_clear_in, fault_clear_in, pulse_block_in, mode_select_in,
    input gear_select_0, gear_select_1, damping_select_0, damping_select_1,
    input cmd_pulse, cmd_dir,
    output alarm_active, servo_on
  );
endinterface

// file: rtl/sci_sync.sv
`timescale 1ns/1ps
// Two-stage synchroniser for a bus of asynchronous levels
module sci_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  // A zero-width bus has nothing to carry
  if (W < 1) begin : g_w_chk
    $error("sync width must be positive");
  end

  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] q;
  } sci_sync_s;
  sci_sync_s st_r;
  sci_sync_s st_nxt;

  // Only the second stage is visible
  always_comb begin
    st_nxt.meta = d_i;
    st_nxt.q = st_r.meta;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign q_o = st_r.q;
endmodule

// file: rtl/sci_host.sv
`timescale 1ns/1ps
// Host end: Wishbone-controlled driver of the discrete lines
module sci_host
  import sci_pkg::*;
#(
  parameter int QUIET_CYC = SCI_MODE_QUIET_CYC,
  parameter int CLR_MIN_CYC = SCI_CLR_MIN_B_CYC
) (
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  output logic irq_o,
  sci_link_if.host link
);
  // Zero counts would make the quiet window and clear hold vanish
  if (QUIET_CYC < 1 || CLR_MIN_CYC < 1) begin : g_cnt_chk
    $error("counts must be positive");
  end

  typedef struct packed {
    logic [10:0] ctrl;
    logic [1:0] limit_act;
    logic ack;
    logic [31:0] rdat;
    logic [2:0] irq;
    logic [2:0] mask;
    logic [31:0] quiet;
    logic [31:0] clr_cnt;
    logic pulse;
    logic dir;
    logic irq_out;
    logic alm_prev;
  } sci_host_s;

  sci_host_s st_r;
  sci_host_s st_nxt;
  logic [1:0] stat_syn;
  logic wr;
  logic rd;

  sci_sync #(
    .W(2)
  ) u_sync (
    .clk_sys_i(clk_sys_i),
    .rst_n_i(rst_n_i),
    .d_i({link.servo_on, link.alarm_active}),
    .q_o(stat_syn)
  );

  assign wr = wb_cyc_i && wb_stb_i && wb_we_i && !st_r.ack && wb_sel_i[0];
  assign rd = wb_cyc_i && wb_stb_i && !st_r.ack;

  // Bus slave, quiet timer and status
  always_comb begin
    logic [2:0] ev;
    ev = '0;
    st_nxt = st_r;
    st_nxt.ack = rd;
    st_nxt.pulse = 1'b0;
    st_nxt.alm_prev = stat_syn[0];
    if (st_r.quiet != 0) st_nxt.quiet = st_r.quiet - 32'h1;
    if (st_r.clr_cnt != 0) st_nxt.clr_cnt = st_r.clr_cnt - 32'h1;
    if (st_r.quiet == 32'h1) ev[SCI_IRQ_MODE_DONE] = 1'b1;
    if (stat_syn[0] && !st_r.alm_prev) ev[SCI_IRQ_ALARM] = 1'b1;
    case (wb_adr_i)
      SCI_REG_CTRL: st_nxt.rdat = {21'h0, st_r.ctrl};
      SCI_REG_CFG: st_nxt.rdat = {30'h0, st_r.limit_act};
      SCI_REG_STAT: st_nxt.rdat = {29'h0, st_r.quiet != 0, stat_syn};
      SCI_REG_IRQ: st_nxt.rdat = {29'h0, st_r.irq};
      SCI_REG_MASK: st_nxt.rdat = {29'h0, st_r.mask};
      default: st_nxt.rdat = 32'h0;
    endcase
    if (wr) begin
      case (wb_adr_i)
        SCI_REG_CTRL: begin
          // Mode flips start the quiet window; clear pulse kept wide enough
          if (wb_dat_i[6] != st_r.ctrl[6]) st_nxt.quiet = QUIET_CYC;
          if (wb_dat_i[3] && !st_r.ctrl[3]) st_nxt.clr_cnt = CLR_MIN_CYC;
          st_nxt.ctrl = wb_dat_i[10:0];
        end
        SCI_REG_CFG: begin
          // Refuse the value that disables the limit inputs
          if (wb_dat_i[1:0] == SCI_LIMIT_ACT_NONE) ev[SCI_IRQ_CFG_ERR] = 1'b1;
          else st_nxt.limit_act = wb_dat_i[1:0];
        end
        SCI_REG_IRQ: st_nxt.irq = st_r.irq & ~wb_dat_i[2:0];
        SCI_REG_MASK: st_nxt.mask = wb_dat_i[2:0];
        SCI_REG_PULSE: begin
          // No commands inside the quiet window
          if (st_r.quiet == 0) begin
            st_nxt.pulse = 1'b1;
            st_nxt.dir = wb_dat_i[0];
          end
        end
        default: ;
      endcase
    end
    // Hold clear until its minimum width has passed
    if (st_r.clr_cnt != 0) st_nxt.ctrl[3] = 1'b1;
    st_nxt.irq = st_nxt.irq | ev; // set wins over clear
    st_nxt.irq_out = |(st_nxt.irq & st_nxt.mask);
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign wb_ack_o = st_r.ack;
  assign wb_dat_o = st_r.rdat;
  assign irq_o = st_r.irq_out;
  assign {link.damping_select_1, link.damping_select_0, link.gear_select_1,
          link.gear_select_0, link.mode_select_in, link.pulse_block_in,
          link.fault_clear_in, link.deviation_clear_in, link.rev_travel_limit_in,
          link.fwd_travel_limit_in, link.servo_enable_in} = st_r.ctrl;
  assign link.cmd_pulse = st_r.pulse;
  assign link.cmd_dir = st_r.dir;
endmodule

// file: dv/sci_link_assertions.sv
`timescale 1ns/1ps
// Drive end checks: two sync stages plus one output register give three cycles of lag
module sci_link_assertions
  import sci_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rst_n_i,
  input wire logic servo_enable_in,
  input wire logic fwd_travel_limit_in,
  input wire logic deviation_clear_in,
  input wire logic pulse_block_in,
  input wire logic mode_select_in,
  input wire logic gear_select_0,
  input wire logic gear_select_1,
  input wire logic [1:0] travel_limit_action_cfg_i,
  input wire logic [2:0] clear_input_mode_cfg_i,
  input wire logic [1:0] pulse_block_disable_cfg_i,
  input wire logic [3:0] clear_line_cfg_i,
  input wire logic [3:0] block_line_cfg_i,
  input wire logic motor_energize_o,
  input wire logic fwd_inhibit_o,
  input wire logic rev_inhibit_o,
  input wire logic dev_clear_o,
  input wire logic cmd_step_o,
  input wire logic cfg_error_o,
  input wire logic loop_select_o,
  input wire logic [1:0] gear_index_o
);
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (!rst_n_i);
  logic lvl_m;
  logic clr_ok;
  logic [1:0] age_r;
  // Line history is unknown for three cycles after reset release
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      age_r <= 2'h0;
    end else if (age_r != 2'h3) begin
      age_r <= age_r + 2'h1;
    end
  end
  // Level modes hold the clear, the others give one pulse per edge
  assign lvl_m = clear_input_mode_cfg_i inside {SCI_CLR_LVL_A, SCI_CLR_LVL_B};
  assign clr_ok = clear_line_cfg_i == SCI_LINE_CLEAR;
  a_servo_follows: assert property (
    age_r == 2'h3 |-> motor_energize_o == $past(servo_enable_in, 3))
    else $error("motor enable does not follow servo input");
  a_fwd_inhibit: assert property (
    travel_limit_action_cfg_i != SCI_LIMIT_ACT_NONE && $past(fwd_travel_limit_in, 3) &&
    $past(travel_limit_action_cfg_i, 3) == travel_limit_action_cfg_i |-> fwd_inhibit_o)
    else $error("forward limit not acted on");
  a_limit_inert: assert property (
    travel_limit_action_cfg_i == SCI_LIMIT_ACT_NONE &&
    $past(travel_limit_action_cfg_i, 3) == SCI_LIMIT_ACT_NONE |-> !fwd_inhibit_o && !rev_inhibit_o)
    else $error("limit inputs acted on while inert");
  a_clear_edge: assert property (
    $rose(deviation_clear_in) && clr_ok && clear_input_mode_cfg_i == SCI_CLR_EDGE_DEF
    |-> ##3 dev_clear_o)
    else $error("clear edge gave no clear pulse");
  a_clear_once: assert property (!lvl_m && dev_clear_o |=> !dev_clear_o)
    else $error("edge mode clear longer than one cycle");
  a_clear_hold: assert property ((lvl_m && clr_ok && deviation_clear_in) [*4] |-> dev_clear_o)
    else $error("level mode clear not held");
  a_clear_line: assert property ((clear_line_cfg_i != SCI_LINE_CLEAR) [*3] |-> cfg_error_o)
    else $error("bad clear line not flagged");
  a_block_line: assert property ((block_line_cfg_i != SCI_LINE_BLOCK) [*3] |-> cfg_error_o)
    else $error("bad block line not flagged");
  a_block_step: assert property (
    (pulse_block_in && pulse_block_disable_cfg_i == 2'h0 && block_line_cfg_i == SCI_LINE_BLOCK)
    [*4] |-> !cmd_step_o)
    else $error("command step passed while blocked");
  a_loop_select: assert property (
    age_r == 2'h3 |-> loop_select_o == $past(mode_select_in, 3))
    else $error("loop select does not follow mode input");
  a_gear_pick: assert property (
    age_r == 2'h3 |-> gear_index_o == $past({gear_select_1, gear_select_0}, 3))
    else $error("gear index does not follow gear inputs");
  // Main traffic seen at least once
  c_hold: cover property (lvl_m && dev_clear_o);
  c_step: cover property (cmd_step_o);
  c_inhibit: cover property (fwd_inhibit_o);
endmodule

// file: dv/tb_top.sv
`timescale 1ns/1ps
module tb_top
  import sci_pkg::*;
  ;
  logic clk_sys_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h00, alarm_raise_i = 8'h00;
  logic [3:0] wb_sel_i = 4'h0, clear_line_cfg_i = 4'h7, block_line_cfg_i = 4'hA;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, q;
  logic [1:0] travel_limit_action_cfg_i = 2'h0, pulse_block_disable_cfg_i = 2'h0;
  logic [2:0] clear_input_mode_cfg_i = 3'h0;
  logic wb_ack_o, irq_o, motor_energize_o, fwd_inhibit_o, rev_inhibit_o, limit_stop_o;
  logic dev_clear_o, cmd_step_o, cmd_dir_o, cfg_error_o, loop_select_o;
  logic [7:0] alarm_o;
  logic [1:0] gear_index_o, damping_index_o;
  int bad_count = 0, n_tests = 0, cyc_n = 0, n_clr, n_step;
  sci_link_if sci_link_if_inst();
  // Short quiet window and clear hold keep the run brief
  sci_host #(.QUIET_CYC(20), .CLR_MIN_CYC(10)) sci_host_inst (.clk_sys_i, .rst_n_i,
    .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o,
    .irq_o, .link(sci_link_if_inst.host));
  sci_drive sci_drive_inst (.clk_sys_i, .rst_n_i, .link(sci_link_if_inst.drive),
    .travel_limit_action_cfg_i, .clear_input_mode_cfg_i, .pulse_block_disable_cfg_i,
    .clear_line_cfg_i, .block_line_cfg_i, .alarm_raise_i, .motor_energize_o, .fwd_inhibit_o,
    .rev_inhibit_o, .limit_stop_o, .dev_clear_o, .cmd_step_o, .cmd_dir_o, .cfg_error_o,
    .alarm_o, .loop_select_o, .gear_index_o, .damping_index_o);
  sci_link_assertions sci_link_assertions_inst (.clk_sys_i, .rst_n_i,
    .servo_enable_in(sci_link_if_inst.servo_enable_in),
    .fwd_travel_limit_in(sci_link_if_inst.fwd_travel_limit_in),
    .deviation_clear_in(sci_link_if_inst.deviation_clear_in),
    .pulse_block_in(sci_link_if_inst.pulse_block_in),
    .mode_select_in(sci_link_if_inst.mode_select_in),
    .gear_select_0(sci_link_if_inst.gear_select_0),
    .gear_select_1(sci_link_if_inst.gear_select_1),
    .travel_limit_action_cfg_i, .clear_input_mode_cfg_i, .pulse_block_disable_cfg_i,
    .clear_line_cfg_i, .block_line_cfg_i, .motor_energize_o, .fwd_inhibit_o, .rev_inhibit_o,
    .dev_clear_o, .cmd_step_o, .cfg_error_o, .loop_select_o, .gear_index_o);
  // 200 MHz clock
  always #2.5 clk_sys_i = ~clk_sys_i;
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_tests++;
    if (s !== e) begin
      bad_count++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask
  // Classic single cycle; holds everything until ack is seen at an edge
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_sel_i <= 4'hF;
    wb_dat_i <= d;
    do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_sys_i);
  endtask
  // Control write, then room for host register plus three cycles of drive lag
  task automatic ctl(input logic [10:0] v);
    wb(1'b1, SCI_REG_CTRL, {21'h0, v});
    repeat (8) @(posedge clk_sys_i);
  endtask
  // Counts clear and step pulses over k cycles
  task automatic cnt(input int k);
    n_clr = 0;
    n_step = 0;
    repeat (k) begin
      @(posedge clk_sys_i);
      n_clr += dev_clear_o;
      n_step += cmd_step_o;
    end
  endtask
  task automatic t_basic;
    ctl(11'h001);
    chk("motor", motor_energize_o, 1'b1);
    wb(1'b0, SCI_REG_STAT, 32'h0);
    chk("servo_on", q[1], 1'b1);
    ctl(11'h000);
    chk("motor", motor_energize_o, 1'b0);
    for (int i = 0; i < 4; i++) begin
      travel_limit_action_cfg_i <= i[1:0];
      ctl(11'h006);
      chk("fwd_inh", fwd_inhibit_o, i != 1);
      chk("rev_inh", rev_inhibit_o, i != 1);
      chk("stop", limit_stop_o, i == 2);
      ctl({i[1:0], i[1:0], 7'h00});
      chk("gear", gear_index_o, i[1:0]);
      chk("damp", damping_index_o, i[1:0]);
    end
  endtask
  task automatic t_clear;
    for (int m = 0; m < 5; m++) begin
      clear_input_mode_cfg_i <= m[2:0];
      // Count from the write itself so an edge-mode pulse is not missed
      wb(1'b1, SCI_REG_CTRL, 32'h8);
      cnt(30);
      ctl(11'h000);
      if (m == 1 || m == 2) begin
        chk("clr_hold", n_clr >= 20, 1'b1);
      end else begin
        chk("clr_once", n_clr, 32'h1);
      end
    end
    clear_input_mode_cfg_i <= SCI_CLR_EDGE_DEF;
    clear_line_cfg_i <= 4'h5;
    wb(1'b1, SCI_REG_CTRL, 32'h8);
    cnt(10);
    chk("clr_err", cfg_error_o, 1'b1);
    chk("clr_bad_line", n_clr, 32'h0);
    clear_line_cfg_i <= SCI_LINE_CLEAR;
    block_line_cfg_i <= 4'h3;
    ctl(11'h000);
    chk("blk_err", cfg_error_o, 1'b1);
    block_line_cfg_i <= SCI_LINE_BLOCK;
  endtask
  task automatic t_block;
    for (int d = 0; d < 3; d++) begin
      pulse_block_disable_cfg_i <= (d == 1) ? 2'h1 : 2'h0;
      ctl((d == 2) ? 11'h000 : 11'h020);
      wb(1'b1, SCI_REG_PULSE, 32'h1);
      cnt(12);
      chk("step", n_step, (d == 0) ? 32'h0 : 32'h1);
    end
    chk("dir", cmd_dir_o, 1'b1);
  endtask
  task automatic t_alarm;
    alarm_raise_i <= 8'h41;
    @(posedge clk_sys_i);
    alarm_raise_i <= 8'h00;
    ctl(11'h010);
    chk("alarm_clr", alarm_o, 8'h40);
  endtask
  task automatic t_mode;
    wb(1'b1, SCI_REG_IRQ, 32'h7);
    wb(1'b1, SCI_REG_MASK, 32'h7);
    wb(1'b1, SCI_REG_CTRL, 32'h40);
    wb(1'b0, SCI_REG_STAT, 32'h0);
    chk("quiet", q[2], 1'b1);
    wb(1'b1, SCI_REG_PULSE, 32'h0);
    cnt(30);
    chk("quiet_step", n_step, 32'h0);
    chk("loop", loop_select_o, 1'b1);
    chk("irq_mode", irq_o, 1'b1);
    wb(1'b1, SCI_REG_IRQ, 32'h2);
    wb(1'b1, SCI_REG_CFG, 32'h1);
    wb(1'b0, SCI_REG_IRQ, 32'h0);
    chk("irq_cfg", q[2:0], 3'h1);
    wb(1'b1, SCI_REG_MASK, 32'h0);
    chk("irq_mask", irq_o, 1'b0);
  endtask
  task automatic test_done;
    $display("Comparisons %0d mismatches %0d", n_tests, bad_count);
    if (bad_count == 0 && n_tests > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard, well above the expected run length
  always @(posedge clk_sys_i) begin
    cyc_n++;
    if (cyc_n == 4000) begin
      bad_count++;
      test_done;
    end
  end
  // Main sequence
  initial begin
    repeat (2) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    t_basic;
    t_clear;
    t_block;
    t_alarm;
    t_mode;
    test_done;
  end
endmodule
